// [common/sts_consts.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the
//          supply and thermal status register bank.
// Assumes: Register addresses are the 7-bit SPI command addresses.
// Notes:   Definitions only; included by bare name.
`ifndef STS_CONSTS_SVH
`define STS_CONSTS_SVH

// Register addresses on the 7-bit command address.
`define STS_ADDR_SUP_A      7'h40
`define STS_ADDR_SUP_B      7'h41
`define STS_ADDR_THERM      7'h42

// Field positions in supply_fail_status_a.
`define STS_A_BATT_UV       6
`define STS_A_AUX_OC        4
`define STS_A_AUX_UV        3
`define STS_A_AUX_OT        2
`define STS_A_MAIN_OV       1
`define STS_A_MAIN_PW       0

// Field positions in supply_fail_status_b.
`define STS_B_POR           7
`define STS_B_HS_UV         6
`define STS_B_HS_OV         5
`define STS_B_SEC_OT        4
`define STS_B_SEC_UV        3
`define STS_B_MAIN_SC       2
`define STS_B_FS_UV         1
`define STS_B_MAIN_UV       0

// Field positions in thermal_protect_status.
`define STS_T_THERMAL_SHUTDOWN_LEVEL_TWO          2
`define STS_T_THERMAL_SHUTDOWN_LEVEL_ONE          1
`define STS_T_TPW           0

// Implemented bits; reserved positions outside these read as zero.
`define STS_SUP_A_MASK      8'h5f
`define STS_THERM_W         3

// Reset values after power-on reset and after a soft reset.
`define STS_SUP_A_RST       8'h00
`define STS_SUP_B_POR_RST   8'h80
`define STS_SUP_B_SOFT_RST  8'h00
`define STS_THERM_RST       3'h0

// Detection vector positions, as they pass the synchroniser.
`define STS_DET_W           14
`define STS_D_BATT_UV       0
`define STS_D_AUX_OC        1
`define STS_D_AUX_UV        2
`define STS_D_AUX_OT        3
`define STS_D_MAIN_OV       4
`define STS_D_MAIN_PW       5
`define STS_D_HS_UV         6
`define STS_D_HS_OV         7
`define STS_D_SEC_OT        8
`define STS_D_SEC_UV        9
`define STS_D_MAIN_UV       10
`define STS_D_FS_UV4        11
`define STS_D_THERMAL_SHUTDOWN_LEVEL_TWO          12
`define STS_D_THERMAL_SHUTDOWN_LEVEL_ONE          13

// Short-to-ground qualification time and clock rate.
`define STS_SC_TIME_US      4000
`define STS_CLK_MHZ         250
`define STS_SC_CNT_W        21

`endif

// [common/sts_pkg.sv]
// Purpose: Types of the supply and thermal status register bank.
// Assumes: Constants come from sts_consts.svh.
// Notes:   State of each module is one packed struct.
`include "sts_consts.svh"

package sts_pkg;

   // Operating mode of the chip, as reported by the mode controller.
   typedef enum logic [2:0]
   {
      STS_MODE_INIT    = 3'b000,
      STS_MODE_NORMAL  = 3'b001,
      STS_MODE_STOP    = 3'b010,
      STS_MODE_SLEEP   = 3'b011,
      STS_MODE_RESTART = 3'b100,
      STS_MODE_FAILSAFE = 3'b101
   } sts_mode_t;

   // Whole state of the register bank.
   typedef struct packed
   {
      logic [7:0]                 sup_a;
      logic [7:0]                 sup_b;
      logic [`STS_THERM_W-1:0]    therm;
      logic [`STS_SC_CNT_W-1:0]   sc_cnt;
      logic                       sc_cond;
      logic                       ro_seen;
      sts_mode_t                  mode_q;
      logic [7:0]                 rd_data;
      logic                       rd_valid;
      logic                       fs_req;
   } sts_state_t;

endpackage : sts_pkg

// [common/sts_sync_if.sv]
// Purpose: Carries detection levels into and out of the synchroniser.
// Assumes: One clock domain; the synchroniser adds two cycles.
// Notes:   Width follows the detection vector.
interface sts_sync_if #(
   parameter int W = 14
) ();
   logic [W-1:0] raw;
   logic [W-1:0] synced;

   modport src  (output raw, input synced);
   modport sync (input raw, output synced);
endinterface : sts_sync_if

// [hdl/sts_sync.sv]
// Purpose: Two-stage synchroniser for the analog detection levels.
// Assumes: Detection levels are slow compared with the clock.
// Notes:   The first stage feeds only the second stage.
module sts_sync #(
   parameter int W = 14
) (
   // Clock and reset.
   input wire logic   clock,
   input wire logic   rst_n,
   // Detection levels in and out.
   sts_sync_if.sync   port
);

   typedef struct packed
   {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sts_sync_st_t;

   sts_sync_st_t st_r;
   sts_sync_st_t st_nxt;

   // Shift the raw levels through two flip-flops.
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.meta   = port.raw;
      st_nxt.stable = st_r.meta;
   end

   // Register the state; reset clears both stages.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign port.synced = st_r.stable;

endmodule : sts_sync

// [hdl/sts_regs.sv]
// Purpose: Sticky supply and thermal fault status registers, read and
//          cleared byte-wise by decoded SPI commands.
// Assumes: The SPI framing is decoded elsewhere into one command strobe
//          with address and access-mode bit; rst_n is the power-on reset.
// Notes:   Read data show the register before any clear of that command.
//
// Behaviour
// - Reserved bits read zero, ignore clears.
// - Status A bit 6 latches battery undervoltage.
// - Auxiliary regulator overcurrent, undervoltage, overtemperature latch.
// - Main regulator overvoltage and prewarning latch.
// - Prewarning uses its own fixed-threshold input.
// - Status B reads 80h after power-on, 00h soft.
// - High-side and second regulator faults latch.
// - Short flag after 4 ms below threshold.
// - Fail-safe entry and each undervoltage latch.
// - Undervoltage flag updates only in allowed modes.
// - Sleep with regulator off sets no main overvoltage, short or undervoltage flag.
// - Thermal shutdowns and prewarning latch; level two forces fail-safe.
// - Thermal flags stay until cleared by command.
// - Restart keeps thermal flags, reserved bits zero.
// - Restart clears fail-safe count flag only.
// - Access bit zero reads, one clears byte.
// - Flags never clear or change on their own.
`include "sts_consts.svh"

module sts_regs #(
   parameter int SC_CYCLES = `STS_SC_TIME_US * `STS_CLK_MHZ
) (
   // Clock and reset.
   input  wire logic                clock,
   input  wire logic                rst_n,
   // Decoded SPI command.
   input  wire logic                cmd_valid,
   input  wire logic [6:0]          cmd_addr,
   input  wire logic                cmd_clear,
   input  wire logic                soft_reset,
   // Answer to the command.
   output logic [7:0]               rd_data,
   output logic                     rd_valid,
   // Chip mode and regulator state.
   input  wire sts_pkg::sts_mode_t  mode,
   input  wire logic                main_reg_on,
   input  wire logic                reset_output_pin_released,
   // Supply detection levels.
   input  wire logic                battery_uv_det,
   input  wire logic                aux_reg_oc_det,
   input  wire logic                aux_reg_uv_det,
   input  wire logic                aux_reg_ot_det,
   input  wire logic                main_reg_ov_det,
   input  wire logic                main_reg_prewarn_det,
   input  wire logic                hs_supply_uv_det,
   input  wire logic                hs_supply_ov_det,
   input  wire logic                second_reg_ot_det,
   input  wire logic                second_reg_uv_det,
   input  wire logic                main_reg_uv_det,
   input  wire logic                failsafe_uv_entry_det,
   // Thermal detection levels.
   input  wire logic                thermal_level_two_det,
   input  wire logic                thermal_level_one_det,
   input  wire logic                thermal_prewarn_det,
   // Fail-safe request from the level-two shutdown flag.
   output logic                     thermal_failsafe_req
);

   import sts_pkg::*;

   localparam int CW = `STS_SC_CNT_W;
   localparam logic [CW-1:0] SC_LIM = CW'(SC_CYCLES);

   // The short timer must hold the qualification count.
   generate
      if (SC_CYCLES < 1 || SC_CYCLES >= (1 << CW))
      begin : g_bad_sc
         $error("SC_CYCLES out of range for the short timer");
      end
   endgenerate

   sts_state_t            st_r;
   sts_state_t            st_nxt;
   logic [`STS_DET_W-1:0] det;
   logic                  thermal_prewarn_sync;

   sts_sync_if #(.W(`STS_DET_W + 1)) sync_bus ();

   // Gather detection levels for synchronising.
   assign sync_bus.raw = {thermal_prewarn_det, thermal_level_one_det,
                          thermal_level_two_det, failsafe_uv_entry_det,
                          main_reg_uv_det, second_reg_uv_det,
                          second_reg_ot_det, hs_supply_ov_det,
                          hs_supply_uv_det, main_reg_prewarn_det,
                          main_reg_ov_det, aux_reg_ot_det,
                          aux_reg_uv_det, aux_reg_oc_det,
                          battery_uv_det};

   // Every detection level passes two flip-flops first.
   sts_sync #(.W(`STS_DET_W + 1)) sts_sync_i (
      .clock (clock),
      .rst_n (rst_n),
      .port  (sync_bus.sync)
   );

   assign det                  = sync_bus.synced[`STS_DET_W-1:0];
   assign thermal_prewarn_sync = sync_bus.synced[`STS_DET_W];

   // Compose the byte that a read of the given address returns.
   function automatic logic [7:0] read_byte(input logic [6:0] addr,
                                            input sts_state_t s);
      logic [7:0] b;
      b = 8'h00;
      case (addr)
         `STS_ADDR_SUP_A: b = s.sup_a & `STS_SUP_A_MASK;
         `STS_ADDR_SUP_B: b = s.sup_b;
         `STS_ADDR_THERM: b = {5'h00, s.therm};
         default:         b = 8'h00;
      endcase
      return b;
   endfunction : read_byte

   // Next-state logic: timer, mode gating, reads, clears and sets.
   always_comb
   begin
      logic       sleep_off;
      logic       uv_update;
      logic       restart_entry;
      logic       clr_a;
      logic       clr_b;
      logic       clr_t;
      logic [7:0] set_a;
      logic [7:0] set_b;
      logic [2:0] set_t;
      sleep_off     = 1'b0;
      uv_update     = 1'b0;
      restart_entry = 1'b0;
      clr_a         = 1'b0;
      clr_b         = 1'b0;
      clr_t         = 1'b0;
      set_a         = 8'h00;
      set_b         = 8'h00;
      set_t         = 3'h0;
      st_nxt        = st_r;
      st_nxt.mode_q = mode;
      st_nxt.rd_valid = 1'b0;

      // Regulator switched off during sleep blocks the main overvoltage, short and undervoltage flags.
      sleep_off = (mode == STS_MODE_SLEEP) && !main_reg_on;

      // Time how long the regulator output stays under threshold.
      if (main_reg_on && det[`STS_D_MAIN_UV])
      begin
         if (st_r.sc_cnt != SC_LIM)
         begin
            st_nxt.sc_cnt = st_r.sc_cnt + CW'(1);
         end
         st_nxt.sc_cond = (st_r.sc_cnt == SC_LIM);
      end
      else
      begin
         st_nxt.sc_cnt  = '0;
         st_nxt.sc_cond = 1'b0;
      end

      // Remember the first release of the reset output in init.
      if (mode == STS_MODE_INIT && reset_output_pin_released)
      begin
         st_nxt.ro_seen = 1'b1;
      end

      // Undervoltage updates in normal and stop, in init after reset release, else under a short.
      case (mode)
         STS_MODE_NORMAL,
         STS_MODE_STOP:    uv_update = 1'b1;
         STS_MODE_INIT:    uv_update = st_r.ro_seen;
         STS_MODE_RESTART: uv_update = st_r.sc_cond;
         default:          uv_update = st_r.sc_cond;
      endcase
      uv_update = uv_update && !sleep_off;

      restart_entry = (mode == STS_MODE_RESTART) &&
                      (st_r.mode_q != STS_MODE_RESTART);

      // Set terms of the first supply register.
      set_a[`STS_A_BATT_UV] = det[`STS_D_BATT_UV];
      set_a[`STS_A_AUX_OC]  = det[`STS_D_AUX_OC];
      set_a[`STS_A_AUX_UV]  = det[`STS_D_AUX_UV];
      set_a[`STS_A_AUX_OT]  = det[`STS_D_AUX_OT];
      set_a[`STS_A_MAIN_OV] = det[`STS_D_MAIN_OV] && !sleep_off;
      set_a[`STS_A_MAIN_PW] = det[`STS_D_MAIN_PW];

      // Set terms of the second supply register.
      set_b[`STS_B_HS_UV]   = det[`STS_D_HS_UV];
      set_b[`STS_B_HS_OV]   = det[`STS_D_HS_OV];
      set_b[`STS_B_SEC_OT]  = det[`STS_D_SEC_OT];
      set_b[`STS_B_SEC_UV]  = det[`STS_D_SEC_UV];
      set_b[`STS_B_MAIN_SC] = st_r.sc_cond && !sleep_off;
      set_b[`STS_B_FS_UV]   = det[`STS_D_FS_UV4];
      set_b[`STS_B_MAIN_UV] = det[`STS_D_MAIN_UV] && uv_update;

      // Set terms of the thermal register.
      set_t[`STS_T_THERMAL_SHUTDOWN_LEVEL_TWO] = det[`STS_D_THERMAL_SHUTDOWN_LEVEL_TWO];
      set_t[`STS_T_THERMAL_SHUTDOWN_LEVEL_ONE] = det[`STS_D_THERMAL_SHUTDOWN_LEVEL_ONE];
      set_t[`STS_T_TPW]  = thermal_prewarn_sync;

      // A command answers with the byte before any clear.
      if (cmd_valid)
      begin
         st_nxt.rd_valid = 1'b1;
         st_nxt.rd_data  = read_byte(cmd_addr, st_r);
         clr_a = cmd_clear && (cmd_addr == `STS_ADDR_SUP_A);
         clr_b = cmd_clear && (cmd_addr == `STS_ADDR_SUP_B);
         clr_t = cmd_clear && (cmd_addr == `STS_ADDR_THERM);
      end

      // A clear command removes the flags of its byte; sets win over clears.
      st_nxt.sup_a = ((clr_a ? 8'h00 : st_r.sup_a) | set_a)
                     & `STS_SUP_A_MASK;
      st_nxt.sup_b = (clr_b ? 8'h00 : st_r.sup_b) | set_b;
      st_nxt.therm = (clr_t ? 3'h0 : st_r.therm) | set_t;

      // Restart entry drops only the fail-safe count flag.
      if (restart_entry && !set_b[`STS_B_FS_UV])
      begin
         st_nxt.sup_b[`STS_B_FS_UV] = 1'b0;
      end
      // Thermal flags pass restart entry untouched.

      st_nxt.fs_req = st_nxt.therm[`STS_T_THERMAL_SHUTDOWN_LEVEL_TWO];

      // Soft reset returns every register to its soft value.
      if (soft_reset)
      begin
         st_nxt.sup_a   = `STS_SUP_A_RST;
         st_nxt.sup_b   = `STS_SUP_B_SOFT_RST;
         st_nxt.therm   = `STS_THERM_RST;
         st_nxt.fs_req  = 1'b0;
         st_nxt.ro_seen = 1'b0;
      end
   end

   // Register the state; power-on reset marks the POR flag.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         st_r        <= '0;
         st_r.sup_b  <= `STS_SUP_B_POR_RST;
         st_r.mode_q <= STS_MODE_INIT;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign rd_data              = st_r.rd_data;
   assign rd_valid             = st_r.rd_valid;
   assign thermal_failsafe_req = st_r.fs_req;

endmodule : sts_regs

// [tb/sts_regs_sva.sv]
// Purpose: Port checks of the status register bank.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Bound to sts_regs after the module.
`include "sts_consts.svh"

module sts_regs_sva #(
   parameter int SC_CYCLES = `STS_SC_TIME_US * `STS_CLK_MHZ
) (
   // Clock and reset.
   input logic       clock,
   input logic       rst_n,
   // Command and answer.
   input logic       cmd_valid,
   input logic [6:0] cmd_addr,
   input logic       cmd_clear,
   input logic       soft_reset,
   input logic [7:0] rd_data,
   input logic       rd_valid,
   // Thermal fail-safe path.
   input logic       thermal_level_two_det,
   input logic       thermal_failsafe_req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic clr_t;
   logic unmapped;
   logic mapped;

   // Decoded thermal clear and address classes.
   assign clr_t    = cmd_valid && cmd_clear && cmd_addr == `STS_ADDR_THERM;
   assign unmapped = cmd_addr < `STS_ADDR_SUP_A || cmd_addr > `STS_ADDR_THERM;
   assign mapped   = !unmapped;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_ANSWER: assert property (cmd_valid |=> rd_valid)
      else $error("answer strobe missing after command");
   AST_NO_ANSWER: assert property (!cmd_valid |=> !rd_valid)
      else $error("answer strobe without command");
   AST_RD_HOLD: assert property (!cmd_valid |=> $stable(rd_data))
      else $error("read byte changed without command");
   AST_UNMAPPED: assert property (cmd_valid && unmapped
      |=> rd_data == 8'h00) else $error("unmapped address gave data");
   AST_RSV_A: assert property (cmd_valid && cmd_addr == `STS_ADDR_SUP_A
      |=> {rd_data[7], rd_data[5]} == 2'h0) else $error("reserved bit set");
   AST_RSV_T: assert property (cmd_valid && cmd_addr == `STS_ADDR_THERM
      |=> rd_data[7:3] == 5'h00) else $error("thermal reserved bit set");
   AST_POR: assert property ($rose(rst_n) ##1
      (cmd_valid && cmd_addr == `STS_ADDR_SUP_B)
      |=> rd_data == `STS_SUP_B_POR_RST) else $error("power-on value wrong");
   AST_SOFT: assert property (soft_reset ##1 (cmd_valid && mapped)
      |=> rd_data == 8'h00) else $error("soft reset left flags");
   AST_TSD_REQ: assert property (
      (thermal_level_two_det && !soft_reset && !clr_t)[*5]
      |-> thermal_failsafe_req) else $error("fail-safe request missing");
   AST_TSD_STICKY: assert property (
      thermal_failsafe_req && !clr_t && !$past(clr_t) && !soft_reset
      && !$past(soft_reset) |=> thermal_failsafe_req)
      else $error("fail-safe request dropped without clear");
endmodule : sts_regs_sva

bind sts_regs sts_regs_sva #(.SC_CYCLES(SC_CYCLES)) sts_regs_sva_i (
   .clock(clock),
   .rst_n(rst_n),
   .cmd_valid(cmd_valid),
   .cmd_addr(cmd_addr),
   .cmd_clear(cmd_clear),
   .soft_reset(soft_reset),
   .rd_data(rd_data),
   .rd_valid(rd_valid),
   .thermal_level_two_det(thermal_level_two_det),
   .thermal_failsafe_req(thermal_failsafe_req)
);

// [tb/sts_mcu.sv]
// Purpose: Microcontroller model sending decoded status commands.
// Assumes: Called at a falling edge; one command per call.
// Notes:   Idle address and mode lines show the inverse of the last value.
module sts_mcu (
   // Clock.
   input  logic       clock,
   // Command out.
   output logic       cmd_valid,
   output logic [6:0] cmd_addr,
   output logic       cmd_clear,
   // Answer in.
   input  logic [7:0] rd_data,
   input  logic       rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle until the first command.
   initial
   begin
      cmd_valid = 1'b0;
      cmd_addr  = 7'h3f;
      cmd_clear = 1'b0;
   end

   // Sends one command, takes the answer, then idles one cycle.
   task automatic xfer(input logic [6:0] a, input logic c,
                       output logic [7:0] d, output logic ok);
      cmd_valid = 1'b1;
      cmd_addr  = a;
      cmd_clear = c;
      @(negedge clock);
      ok        = rd_valid;
      d         = rd_data;
      cmd_valid = 1'b0;
      cmd_addr  = ~a;
      cmd_clear = ~c;
      @(negedge clock);
   endtask : xfer
endmodule : sts_mcu

// [tb/supply_thermal_status_regs_bench.sv]
// Purpose: Self-checking bench of the status register bank.
// Assumes: Inputs change at falling edges; short count shortened.
// Notes:   Commands go through the microcontroller model.
`include "sts_consts.svh"

module supply_thermal_status_regs_bench
   import sts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SC = 20;
   // Expected flag of each detection input, in port order.
   localparam logic [7:0] MASK [15] = '{8'h40, 8'h10, 8'h08, 8'h04,
      8'h02, 8'h01, 8'h40, 8'h20, 8'h10, 8'h08, 8'h01, 8'h02, 8'h04,
      8'h02, 8'h01};
   logic        clock;
   logic        rst_n;
   logic        soft_reset;
   sts_mode_t   mode;
   logic        main_reg_on;
   logic        ro_rel;
   logic [14:0] det;
   logic        cmd_valid;
   logic [6:0]  cmd_addr;
   logic        cmd_clear;
   logic [7:0]  rd_data;
   logic        rd_valid;
   logic        tfs_req;
   int          mismatches;
   int          comparisons;

   sts_regs #(.SC_CYCLES(SC)) sts_regs_i (
      .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_addr(cmd_addr), .cmd_clear(cmd_clear), .soft_reset(soft_reset),
      .rd_data(rd_data), .rd_valid(rd_valid), .mode(mode),
      .main_reg_on(main_reg_on), .reset_output_pin_released(ro_rel),
      .battery_uv_det(det[0]), .aux_reg_oc_det(det[1]),
      .aux_reg_uv_det(det[2]), .aux_reg_ot_det(det[3]),
      .main_reg_ov_det(det[4]), .main_reg_prewarn_det(det[5]),
      .hs_supply_uv_det(det[6]), .hs_supply_ov_det(det[7]),
      .second_reg_ot_det(det[8]), .second_reg_uv_det(det[9]),
      .main_reg_uv_det(det[10]), .failsafe_uv_entry_det(det[11]),
      .thermal_level_two_det(det[12]), .thermal_level_one_det(det[13]),
      .thermal_prewarn_det(det[14]), .thermal_failsafe_req(tfs_req));

   sts_mcu sts_mcu_i (
      .clock(clock), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
      .cmd_clear(cmd_clear), .rd_data(rd_data), .rd_valid(rd_valid));

   // Free-running 250 MHz clock.
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Compares one value and counts it.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Issues one command and checks strobe and byte.
   task automatic acc(input logic [6:0] a, input logic c,
                      input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      sts_mcu_i.xfer(a, c, d, ok);
      check({7'h00, ok}, 8'h01);
      check(d, exp);
   endtask : acc

   // Raises one detection for n cycles, then lets it settle.
   task automatic pulse(input int i, input int n);
      det[i] = 1'b1;
      repeat (n) @(negedge clock);
      det[i] = 1'b0;
      repeat (4) @(negedge clock);
   endtask : pulse

   // Prints counts and the verdict, then stops.
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict

   // Cuts a hang short well beyond the expected run.
   initial
   begin
      repeat (5000) @(posedge clock);
      mismatches++;
      $display("mismatch at %0t: watchdog expired", $time);
      print_verdict();
   end

   // Test sequence.
   initial
   begin
      logic [6:0] a;
      {rst_n, soft_reset, det, mismatches, comparisons} = '0;
      mode                  = STS_MODE_NORMAL;
      {main_reg_on, ro_rel} = 2'b11;
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      acc(`STS_ADDR_SUP_B, 1'b0, `STS_SUP_B_POR_RST);
      acc(`STS_ADDR_SUP_B, 1'b1, `STS_SUP_B_POR_RST);
      acc(`STS_ADDR_SUP_A, 1'b0, 8'h00);
      acc(`STS_ADDR_THERM, 1'b0, 8'h00);
      acc(7'h43, 1'b1, 8'h00);
      acc(`STS_ADDR_SUP_B, 1'b0, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 15; i++)
      begin
         a = i < 6 ? `STS_ADDR_SUP_A : i < 12 ? `STS_ADDR_SUP_B
                                              : `STS_ADDR_THERM;
         pulse(i, 5);
         if (i == 12)
            check({7'h00, tfs_req}, 8'h01);
         acc(a, 1'b0, MASK[i]);
         acc(a, 1'b1, MASK[i]);
         if (i == 12)
            check({7'h00, tfs_req}, 8'h00);
         acc(a, 1'b0, 8'h00);
      end
      $display("test flags done");
      det[0] = 1'b1;
      repeat (4) @(negedge clock);
      acc(`STS_ADDR_SUP_A, 1'b1, 8'h40);
      acc(`STS_ADDR_SUP_A, 1'b0, 8'h40);
      det[0] = 1'b0;
      repeat (3) @(negedge clock);
      acc(`STS_ADDR_SUP_A, 1'b1, 8'h40);
      $display("test set beats clear done");
      mode                 = STS_MODE_INIT;
      {ro_rel, soft_reset} = 2'b01;
      @(negedge clock);
      soft_reset = 1'b0;
      acc(`STS_ADDR_SUP_B, 1'b0, `STS_SUP_B_SOFT_RST);
      pulse(10, 3);
      acc(`STS_ADDR_SUP_B, 1'b0, 8'h00);
      ro_rel = 1'b1;
      pulse(10, 3);
      pulse(11, 3);
      pulse(14, 3);
      acc(`STS_ADDR_SUP_B, 1'b0, 8'h03);
      mode = STS_MODE_RESTART;
      @(negedge clock);
      acc(`STS_ADDR_SUP_B, 1'b1, 8'h01);
      acc(`STS_ADDR_THERM, 1'b0, 8'h01);
      pulse(10, 3);
      acc(`STS_ADDR_SUP_B, 1'b0, 8'h00);
      $display("test modes done");
      mode        = STS_MODE_SLEEP;
      main_reg_on = 1'b0;
      pulse(4, 3);
      pulse(10, 3);
      acc(`STS_ADDR_SUP_A, 1'b0, 8'h00);
      acc(`STS_ADDR_SUP_B, 1'b0, 8'h00);
      acc(`STS_ADDR_THERM, 1'b1, 8'h01);
      $display("test sleep done");
      mode        = STS_MODE_STOP;
      main_reg_on = 1'b1;
      pulse(10, SC);
      acc(`STS_ADDR_SUP_B, 1'b1, 8'h01);
      pulse(10, SC + 4);
      acc(`STS_ADDR_SUP_B, 1'b1, 8'h05);
      mode = STS_MODE_RESTART;
      pulse(10, SC + 4);
      acc(`STS_ADDR_SUP_B, 1'b0, 8'h05);
      $display("test short done");
      print_verdict();
   end
endmodule : supply_thermal_status_regs_bench
